// ---- hdl/tcac_pkg.sv ----
// Package of offsets, fields, resets and states for the transfer count block
package tcac_pkg;

    localparam int          DATA_W        = 32;
    localparam int          ADDR_W        = 8;

    // Register byte offsets
    localparam logic [7:0]  OFF_COUNT_A   = 8'h00;
    localparam logic [7:0]  OFF_COUNT_B   = 8'h04;
    localparam logic [7:0]  OFF_MODE      = 8'h08;
    localparam logic [7:0]  OFF_STATUS    = 8'h0c;
    localparam logic [7:0]  OFF_ACT_EN0   = 8'h10;
    localparam logic [7:0]  OFF_SW_VECTOR = 8'h30;
    localparam logic [7:0]  OFF_MSTOP     = 8'h34;
    localparam logic [7:0]  OFF_VEC_ADDR  = 8'h38;

    // Mode register fields
    localparam int          MODE_LSB      = 2;
    localparam int          MODE_MSB      = 3;
    localparam int          ISEL_BIT      = 6;

    // Software vector register fields
    localparam int          SWAE_BIT      = 7;
    localparam int          VEC_W         = 7;

    // Module stop register fields
    localparam int          CSTOP_BIT     = 6;

    // Status register fields
    localparam int          ST_BUSY_BIT   = 0;
    localparam int          ST_SWEND_BIT  = 1;
    localparam int          ST_EXH_BIT    = 2;
    localparam int          ST_STOP_BIT   = 3;

    // Reset values
    localparam logic [7:0]  ACT_EN_RST    = 8'h00;
    localparam logic [7:0]  SW_VECTOR_RST = 8'h00;
    localparam logic [7:0]  MSTOP_RST     = 8'h3f;
    localparam logic [15:0] COUNT_RST     = 16'h0000;
    localparam logic [7:0]  MODE_RST      = 8'h00;

    // Software activation vector base
    localparam logic [15:0] VEC_BASE      = 16'h0400;

    // Transfer mode encodings
    localparam logic [1:0]  MODE_NORMAL   = 2'b00;
    localparam logic [1:0]  MODE_REPEAT   = 2'b01;

    typedef enum logic [1:0] {
        TCAC_IDLE,
        TCAC_XFER,
        TCAC_END
    } tcac_state_e;

endpackage

// ---- hdl/tcac_top.sv ----
// Transfer count, activation enable, software vector and module stop control
// Operation
// - Normal mode: 16-bit count decrements per transfer, ends at zero.
// - Repeat/block mode: upper byte is reload, lower byte counts 1 to 256.
// - Repeat/block mode: lower byte decrements, reloads from upper at zero.
// - Block mode: 16-bit block count decrements per block, ends at zero.
// - Seven 8-bit enable registers; set bit routes a source here.
// - Enable registers clear on reset and hardware standby.
// - Enable bit clears on select-and-ended or count exhausted, else held.
// - Software vector register resets to zero, enable bit included.
// - Software activation enable accepts only written ones.
// - Soft enable clears: select zero unexhausted, or select zeroed later.
// - Soft enable held during transfer, on select-and-ended, or exhausted.
// - Vector address is base 0x0400 plus vector number shifted left once.
// - Vector number bits are writable only while soft enable is zero.
// - Stop bit set halts controller after current cycle, enters stop mode.
// - Stop bit cannot be set to one while the controller is operating.
// - Stop register resets to 0x3F, untouched by software standby.
// - Mode field: 00 normal, 01 repeat, 1x block transfer.
// - Select bit chooses flag clear (zero) or CPU interrupt (one).
`timescale 1ns/1ps

module tcac_top #(
    parameter int SRC_REGS = 7
) (
    input  wire logic                          pclk,
    input  wire logic                          presetn,
    input  wire logic                          hw_standby,
    input  wire logic                          psel,
    input  wire logic                          penable,
    input  wire logic                          pwrite,
    input  wire logic [tcac_pkg::ADDR_W-1:0]   paddr,
    input  wire logic [tcac_pkg::DATA_W-1:0]   pwdata,
    input  wire logic [3:0]                    pstrb,
    output logic      [tcac_pkg::DATA_W-1:0]   prdata,
    output logic                               pready,
    output logic                               pslverr,
    input  wire logic [SRC_REGS*8-1:0]         src_req,
    output logic                               xfer_pulse,
    output logic      [15:0]                   xfer_vector,
    output logic                               src_flag_clr,
    output logic                               src_cpu_req,
    output logic      [5:0]                    src_index,
    output logic                               sw_end_irq,
    output logic                               busy,
    output logic                               module_stopped
);
    import tcac_pkg::*;

    localparam int NSRC = SRC_REGS * 8;

    if (SRC_REGS < 1 || SRC_REGS > 8) begin : g_src_regs_check
        $error("SRC_REGS must lie between 1 and 8");
    end

    // Lowest pending enabled source wins, matching fixed default priority
    function automatic logic [5:0] first_set(input logic [63:0] v);
        logic [5:0] idx;
        idx = 6'h00;
        for (int i = 63; i >= 0; i--) begin
            if (v[i]) begin
                idx = 6'(i);
            end
        end
        return idx;
    endfunction

    function automatic logic [15:0] vec_addr(input logic [VEC_W-1:0] n);
        return VEC_BASE + {8'h00, n, 1'b0};
    endfunction

    logic [15:0]        count_a_r;
    logic [15:0]        count_b_r;
    logic [7:0]         mode_r;
    logic [7:0]         act_en_r [SRC_REGS];
    logic               swae_r;
    logic [VEC_W-1:0]   vec_num_r;
    logic [7:0]         mstop_r;
    logic               sw_end_r;
    logic               exh_r;
    logic               from_sw_r;
    logic [5:0]         src_idx_r;
    tcac_state_e        state_r;
    logic [DATA_W-1:0]  prdata_r;
    logic               xfer_pulse_r;
    logic               flag_clr_r;
    logic               cpu_req_r;
    logic [15:0]        xfer_vec_r;

    logic [63:0]        en_flat;
    logic [63:0]        pend;
    logic               hw_pend;
    logic               stop_bit;
    logic               start;
    logic               wr_en;
    logic               rd_setup;
    logic               mapped;
    logic               act_hit;
    logic [2:0]         act_sel;
    logic [1:0]         mode;
    logic               is_block;
    logic               lo_zero_nxt;
    logic               unit_last;
    logic               seq_exh;
    logic               isel;
    logic [7:0]         hw_clr [SRC_REGS];

    // Flattened so one priority search covers every enable register
    always_comb begin
        en_flat = 64'h0;
        for (int r = 0; r < SRC_REGS; r++) begin
            en_flat[r*8 +: 8] = act_en_r[r];
        end
    end

    // Only enabled sources activate; others stay with the CPU
    assign pend     = en_flat & 64'(src_req);
    assign hw_pend  = |pend;
    assign stop_bit = mstop_r[CSTOP_BIT];
    assign mode     = mode_r[MODE_MSB:MODE_LSB];
    assign is_block = mode[1];
    assign isel     = mode_r[ISEL_BIT];
    // Stopped controller accepts no new activation
    assign start    = (state_r == TCAC_IDLE) && !stop_bit && (hw_pend || swae_r
                      && !sw_end_r);

    // APB decode
    assign wr_en    = psel && penable && pwrite;
    assign rd_setup = psel && !penable && !pwrite;
    assign act_hit  = (paddr >= OFF_ACT_EN0) && (paddr[1:0] == 2'b00)
                      && (paddr < OFF_ACT_EN0 + 8'(SRC_REGS * 4));
    assign act_sel  = 3'((paddr - OFF_ACT_EN0) >> 2);
    assign mapped   = act_hit || paddr == OFF_COUNT_A || paddr == OFF_COUNT_B
                      || paddr == OFF_MODE || paddr == OFF_STATUS
                      || paddr == OFF_SW_VECTOR || paddr == OFF_MSTOP
                      || paddr == OFF_VEC_ADDR;
    // No wait states: every register answers in the access cycle
    assign pready   = 1'b1;
    assign pslverr  = psel && penable && !mapped;

    // Counter step for one transfer unit
    // A loaded zero simply wraps, which gives the maximum count for free
    assign lo_zero_nxt = (count_a_r[7:0] == 8'h01);
    always_comb begin
        unit_last = 1'b1;
        seq_exh   = 1'b0;
        if (mode == MODE_NORMAL) begin
            seq_exh = (count_a_r == 16'h0001);
        end else if (mode == MODE_REPEAT) begin
            seq_exh = 1'b0;
        end else begin
            unit_last = lo_zero_nxt;
            seq_exh   = lo_zero_nxt && (count_b_r == 16'h0001);
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_r      <= TCAC_IDLE;
            src_idx_r    <= 6'h00;
            from_sw_r    <= 1'b0;
            exh_r        <= 1'b0;
            xfer_pulse_r <= 1'b0;
            xfer_vec_r   <= 16'h0000;
        end else if (hw_standby) begin
            // Standby abandons a transfer without any outcome pulse
            state_r      <= TCAC_IDLE;
            src_idx_r    <= 6'h00;
            from_sw_r    <= 1'b0;
            xfer_vec_r   <= 16'h0000;
            exh_r        <= 1'b0;
            xfer_pulse_r <= 1'b0;
        end else begin
            xfer_pulse_r <= 1'b0;
            case (state_r)
                TCAC_IDLE: begin
                    if (start) begin
                        state_r   <= TCAC_XFER;
                        from_sw_r <= !hw_pend;
                        src_idx_r <= first_set(pend);
                        exh_r     <= 1'b0;
                        xfer_vec_r <= hw_pend ? 16'h0000 : vec_addr(vec_num_r);
                    end
                end
                TCAC_XFER: begin
                    xfer_pulse_r <= 1'b1;
                    if (unit_last) begin
                        state_r <= TCAC_END;
                        exh_r   <= seq_exh;
                    end
                end
                TCAC_END: begin
                    state_r <= TCAC_IDLE;
                end
                default: begin
                    state_r <= TCAC_IDLE;
                end
            endcase
        end
    end

    // Counters; APB writes are ignored while a transfer runs
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            count_a_r <= COUNT_RST;
            count_b_r <= COUNT_RST;
        end else if (state_r == TCAC_XFER) begin
            if (mode == MODE_NORMAL) begin
                count_a_r <= count_a_r - 16'h0001;
            end else if (count_a_r[7:0] == 8'h01) begin
                count_a_r[7:0] <= count_a_r[15:8];
                if (is_block) begin
                    count_b_r <= count_b_r - 16'h0001;
                end
            end else begin
                count_a_r[7:0] <= count_a_r[7:0] - 8'h01;
            end
        end else if (wr_en && paddr == OFF_COUNT_A) begin
            count_a_r <= pwdata[15:0];
        end else if (wr_en && paddr == OFF_COUNT_B) begin
            count_b_r <= pwdata[15:0];
        end
    end

    // Mode is left alone by standby, like the counts
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            mode_r <= MODE_RST;
        end else if (wr_en && paddr == OFF_MODE) begin
            mode_r <= pwdata[7:0];
        end
    end

    // End-of-transfer outcome for a hardware source
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            flag_clr_r <= 1'b0;
            cpu_req_r  <= 1'b0;
        end else begin
            flag_clr_r <= 1'b0;
            cpu_req_r  <= 1'b0;
            if (state_r == TCAC_END && !from_sw_r && !hw_standby) begin
                flag_clr_r <= !isel && !exh_r;
                cpu_req_r  <= isel || exh_r;
            end
        end
    end

    // Only the served source loses its enable, when passed to the CPU
    always_comb begin
        for (int r = 0; r < SRC_REGS; r++) begin
            hw_clr[r] = 8'h00;
            if (state_r == TCAC_END && !from_sw_r && (isel || exh_r)
                && 3'(src_idx_r >> 3) == 3'(r)) begin
                hw_clr[r][src_idx_r[2:0]] = 1'b1;
            end
        end
    end

    // Hardware clear applied after the software write of the same cycle
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            for (int r = 0; r < SRC_REGS; r++) begin
                act_en_r[r] <= ACT_EN_RST;
            end
        end else if (hw_standby) begin
            for (int r = 0; r < SRC_REGS; r++) begin
                act_en_r[r] <= ACT_EN_RST;
            end
        end else begin
            for (int r = 0; r < SRC_REGS; r++) begin
                if (wr_en && act_hit && act_sel == 3'(r) && pstrb[0]) begin
                    act_en_r[r] <= pwdata[7:0] & ~hw_clr[r];
                end else begin
                    act_en_r[r] <= act_en_r[r] & ~hw_clr[r];
                end
            end
        end
    end

    // Software activation enable, vector and end flag
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            swae_r    <= 1'b0;
            vec_num_r <= '0;
            sw_end_r  <= 1'b0;
        end else if (hw_standby) begin
            swae_r    <= 1'b0;
            vec_num_r <= '0;
            sw_end_r  <= 1'b0;
        end else begin
            if (wr_en && paddr == OFF_SW_VECTOR && pstrb[0]) begin
                if (!swae_r) begin
                    vec_num_r <= pwdata[VEC_W-1:0];
                end
            end
            // End-of-transfer set outranks a select write in the same cycle
            if (state_r == TCAC_END && from_sw_r) begin
                if (!isel && !exh_r) begin
                    swae_r <= 1'b0;
                end else begin
                    sw_end_r <= 1'b1;
                end
            end else if (wr_en && paddr == OFF_MODE && !pwdata[ISEL_BIT]
                         && sw_end_r) begin
                swae_r   <= 1'b0;
                sw_end_r <= 1'b0;
            end
            // A written one wins over any hardware clear
            if (wr_en && paddr == OFF_SW_VECTOR && pstrb[0]
                && pwdata[SWAE_BIT]) begin
                swae_r <= 1'b1;
            end
        end
    end

    // Module stop; the controller bit is refused while busy
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            mstop_r <= MSTOP_RST;
        end else if (hw_standby) begin
            mstop_r <= MSTOP_RST;
        end else if (wr_en && paddr == OFF_MSTOP && pstrb[0]) begin
            mstop_r <= pwdata[7:0];
            if (state_r != TCAC_IDLE && !mstop_r[CSTOP_BIT]) begin
                mstop_r[CSTOP_BIT] <= 1'b0;
            end
        end
    end

    // Read data captured in the setup cycle
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata_r <= '0;
        end else if (rd_setup) begin
            prdata_r <= '0;
            if (act_hit) begin
                prdata_r[7:0] <= act_en_r[act_sel];
            end else begin
                case (paddr)
                    OFF_COUNT_A:   prdata_r[15:0] <= count_a_r;
                    OFF_COUNT_B:   prdata_r[15:0] <= count_b_r;
                    OFF_MODE:      prdata_r[7:0]  <= mode_r;
                    OFF_STATUS: begin
                        prdata_r[ST_BUSY_BIT]  <= state_r != TCAC_IDLE;
                        prdata_r[ST_SWEND_BIT] <= sw_end_r;
                        prdata_r[ST_EXH_BIT]   <= exh_r;
                        prdata_r[ST_STOP_BIT]  <= module_stopped;
                    end
                    OFF_SW_VECTOR: prdata_r[7:0]  <= {swae_r, vec_num_r};
                    OFF_MSTOP:     prdata_r[7:0]  <= mstop_r;
                    OFF_VEC_ADDR:  prdata_r[15:0] <= vec_addr(vec_num_r);
                    default:       prdata_r       <= '0;
                endcase
            end
        end
    end

    assign prdata         = prdata_r;
    assign xfer_pulse     = xfer_pulse_r;
    assign xfer_vector    = xfer_vec_r;
    assign src_flag_clr   = flag_clr_r;
    assign src_cpu_req    = cpu_req_r;
    assign src_index      = src_idx_r;
    assign sw_end_irq     = sw_end_r;
    assign busy           = state_r != TCAC_IDLE;
    // Stop takes hold only once the engine is idle
    assign module_stopped = stop_bit && state_r == TCAC_IDLE;

endmodule

// ---- sim/tcac_partner.sv ----
// Interrupt controller model holding activation flags
`timescale 1ns/1ps
module tcac_partner (
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic [55:0] raise,
    input  wire logic [55:0] drop,
    input  wire logic        src_flag_clr,
    input  wire logic [5:0]  src_index,
    output logic      [55:0] src_req
);
    logic [55:0] flag_r;
    logic [55:0] clr_mask;
    // Clear is seen at once so a served flag cannot restart the engine
    assign clr_mask = src_flag_clr ? (56'h1 << src_index) : 56'h0;
    assign src_req  = flag_r & ~clr_mask;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            flag_r <= 56'h0;
        end else begin
            flag_r <= (flag_r | raise) & ~drop & ~clr_mask;
        end
    end
endmodule

// ---- sim/tcac_checker.sv ----
// Port checker for the transfer count and activation block
`timescale 1ns/1ps
module tcac_checker (
    input wire logic        pclk,
    input wire logic        presetn,
    input wire logic        busy,
    input wire logic        xfer_pulse,
    input wire logic [15:0] xfer_vector,
    input wire logic        src_flag_clr,
    input wire logic        src_cpu_req,
    input wire logic        module_stopped
);
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    a_pulse_after_start: assert property (
        $rose(busy) |=> xfer_pulse) else $error("no unit after start");
    a_busy_bounded: assert property (
        $rose(busy) |-> ##[1:300] !busy) else $error("transfer hangs");
    a_stopped_no_start: assert property (
        module_stopped |=> !busy) else $error("start while stopped");
    a_stopped_no_unit: assert property (
        module_stopped |-> !xfer_pulse) else $error("unit while stopped");
    a_outcome_exclusive: assert property (
        !(src_flag_clr && src_cpu_req)) else $error("both outcomes");
    a_vector_base: assert property (
        xfer_pulse && xfer_vector != 16'h0000 |->
        xfer_vector[15:9] == 7'h02 && !xfer_vector[0])
        else $error("bad vector address");
    a_outcome_after_end: assert property (
        src_flag_clr || src_cpu_req |-> !busy && $past(busy))
        else $error("outcome out of place");
    a_unit_needs_busy: assert property (
        xfer_pulse |-> $past(busy)) else $error("unit while idle");
endmodule

bind tcac_top tcac_checker tcac_checker_i (
    .pclk           (pclk),
    .presetn        (presetn),
    .busy           (busy),
    .xfer_pulse     (xfer_pulse),
    .xfer_vector    (xfer_vector),
    .src_flag_clr   (src_flag_clr),
    .src_cpu_req    (src_cpu_req),
    .module_stopped (module_stopped)
);

// ---- sim/tcac_top_tb.sv ----
// Self-checking bench for the transfer count and activation block
`timescale 1ns/1ps
module tcac_top_tb;
    import tcac_pkg::*;
    logic        pclk, presetn, hw_standby, psel, penable, pwrite;
    logic [7:0]  paddr;
    logic [31:0] pwdata, prdata, rd;
    logic [3:0]  pstrb;
    logic        pready, pslverr, err, xfer_pulse, src_flag_clr;
    logic        src_cpu_req, sw_end_irq, busy, module_stopped;
    logic [55:0] src_req, raise, drop;
    logic [15:0] xfer_vector, last_vec;
    logic [5:0]  src_index;
    int          fails, tests_run, n_xfer, n_clr, n_cpu, b;
    int          cyc = 0;
    tcac_top #(.SRC_REGS(7)) tcac_top_i (.pclk(pclk), .presetn(presetn),
        .hw_standby(hw_standby), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
        .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .src_req(src_req), .xfer_pulse(xfer_pulse),
        .xfer_vector(xfer_vector), .src_flag_clr(src_flag_clr),
        .src_cpu_req(src_cpu_req), .src_index(src_index),
        .sw_end_irq(sw_end_irq), .busy(busy),
        .module_stopped(module_stopped));
    tcac_partner tcac_partner_i (.pclk(pclk), .presetn(presetn),
        .raise(raise), .drop(drop), .src_flag_clr(src_flag_clr),
        .src_index(src_index), .src_req(src_req));
    initial begin
        pclk = 1'b0;
        forever #50 pclk = ~pclk;
    end
    always @(posedge pclk) begin
        cyc <= cyc + 1;
        if (xfer_pulse === 1'b1) begin
            n_xfer++;
            last_vec = xfer_vector;
        end
        if (src_flag_clr === 1'b1) n_clr++;
        if (src_cpu_req === 1'b1) n_cpu++;
        // Run needs under a thousand cycles
        if (cyc == 5000) begin
            fails++;
            give_verdict();
        end
    end
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        tests_run++;
        if (got !== exp) begin
            fails++;
            $display("[ERR] %0t got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic apb(input logic w, input logic [7:0] a,
                       input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1) @(posedge pclk);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        apb(1'b1, a, d);
    endtask
    task automatic rdc(input logic [7:0] a, input logic [31:0] e);
        apb(1'b0, a, 32'h0);
        chk(rd, e);
    endtask
    task automatic wait_done();
        while (busy !== 1'b1) @(posedge pclk);
        while (busy !== 1'b0) @(posedge pclk);
        repeat (3) @(posedge pclk);
    endtask
    task automatic rais(input int n);
        @(posedge pclk);
        raise <= 56'h1 << n;
        @(posedge pclk);
        raise <= 56'h0;
    endtask
    task automatic clr(input int n);
        @(posedge pclk);
        drop <= 56'h1 << n;
        @(posedge pclk);
        drop <= 56'h0;
    endtask
    task automatic t_reset();
        for (int r = 0; r < 7; r++) rdc(OFF_ACT_EN0 + 8'(4 * r), 32'h0);
        rdc(OFF_SW_VECTOR, 32'h0);
        rdc(OFF_MSTOP, 32'h3f);
        apb(1'b0, 8'h3c, 32'h0);
        chk(err, 32'h1);
        $display("reset test done");
    endtask
    task automatic t_normal();
        wr(OFF_MODE, 32'h00);
        wr(OFF_COUNT_A, 32'h2);
        apb(1'b0, OFF_ACT_EN0, 32'h0);
        wr(OFF_ACT_EN0, rd | 32'h08);
        rais(3);
        wait_done();
        rdc(OFF_COUNT_A, 32'h1);
        chk(last_vec, 32'h0);
        chk(n_clr, 32'h1);
        rdc(OFF_ACT_EN0, 32'h08);
        rais(3);
        wait_done();
        rdc(OFF_COUNT_A, 32'h0);
        chk(n_cpu, 32'h1);
        rdc(OFF_ACT_EN0, 32'h00);
        clr(3);
        wr(OFF_MODE, 32'h04);
        wr(OFF_COUNT_A, 32'h0201);
        wr(OFF_ACT_EN0 + 8'h04, 32'h02);
        rais(9);
        wait_done();
        chk(src_index, 32'd9);
        rdc(OFF_COUNT_A, 32'h0202);
        chk(n_clr, 32'h2);
        rdc(OFF_ACT_EN0 + 8'h04, 32'h02);
        wr(OFF_ACT_EN0 + 8'h04, 32'h00);
        $display("normal and repeat test done");
    endtask
    task automatic t_block();
        for (int m = 0; m < 2; m++) begin
            wr(OFF_MODE, m ? 32'h0c : 32'h08);
            wr(OFF_COUNT_A, m ? 32'h0 : 32'h0303);
            wr(OFF_COUNT_B, 32'h1);
            wr(OFF_ACT_EN0, 32'h01);
            b = n_xfer;
            rais(0);
            wait_done();
            chk(n_xfer - b, m ? 256 : 3);
            rdc(OFF_COUNT_B, 32'h0);
            rdc(OFF_COUNT_A, m ? 32'h0 : 32'h0303);
            rdc(OFF_ACT_EN0, 32'h0);
            clr(0);
        end
        chk(n_cpu, 32'h3);
        $display("block test done");
    endtask
    task automatic t_soft();
        wr(OFF_MODE, 32'h00);
        wr(OFF_COUNT_A, 32'h5);
        wr(OFF_SW_VECTOR, 32'h90);
        wait_done();
        chk(last_vec, 32'h0420);
        rdc(OFF_SW_VECTOR, 32'h10);
        wr(OFF_MODE, 32'h40);
        wr(OFF_SW_VECTOR, 32'h90);
        wait_done();
        rdc(OFF_SW_VECTOR, 32'h90);
        chk(sw_end_irq, 32'h1);
        wr(OFF_SW_VECTOR, 32'h85);
        rdc(OFF_SW_VECTOR, 32'h90);
        wr(OFF_SW_VECTOR, 32'h00);
        rdc(OFF_SW_VECTOR, 32'h90);
        wr(OFF_MODE, 32'h00);
        rdc(OFF_SW_VECTOR, 32'h10);
        chk(sw_end_irq, 32'h0);
        $display("software test done");
    endtask
    task automatic t_stop();
        wr(OFF_MSTOP, 32'h7f);
        @(posedge pclk);
        chk(module_stopped, 32'h1);
        wr(OFF_ACT_EN0, 32'h01);
        b = n_xfer;
        rais(0);
        repeat (10) @(posedge pclk);
        chk(n_xfer, b);
        wr(OFF_MSTOP, 32'h3f);
        wait_done();
        chk(n_xfer, b + 1);
        wr(OFF_MODE, 32'h0c);
        wr(OFF_COUNT_A, 32'h0);
        wr(OFF_COUNT_B, 32'h5);
        rais(0);
        while (busy !== 1'b1) @(posedge pclk);
        wr(OFF_MSTOP, 32'h7f);
        rdc(OFF_MSTOP, 32'h3f);
        wait_done();
        wr(OFF_MSTOP, 32'h7f);
        @(posedge pclk);
        hw_standby <= 1'b1;
        @(posedge pclk);
        hw_standby <= 1'b0;
        rdc(OFF_ACT_EN0, 32'h0);
        rdc(OFF_MSTOP, 32'h3f);
        rdc(OFF_SW_VECTOR, 32'h0);
        $display("stop and standby test done");
    endtask
    task automatic give_verdict();
        $display("checks %0d mismatches %0d", tests_run, fails);
        if (fails == 0 && tests_run > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask
    initial begin
        {presetn, hw_standby, psel, penable, pwrite} = 5'h0;
        {paddr, pwdata, raise, drop} = '0;
        pstrb = 4'hf;
        repeat (20) @(posedge pclk);
        presetn <= 1'b1;
        t_reset();
        t_normal();
        t_block();
        t_soft();
        t_stop();
        give_verdict();
    end
endmodule
